// ==== rivu_defs.vh ====
/*
  Constants for the reset and interrupt vector unit: vector word addresses,
  source count and boot reset address. Assumes inclusion by bare name.
*/
`ifndef RIVU_DEFS_VH
`define RIVU_DEFS_VH

`define RIVU_NUM_SRC      17
`define RIVU_PC_W         13
`define RIVU_VEC_W        5
`define RIVU_RESET_VEC    13'h0000
`define RIVU_BOOT_VEC     13'h1F00
`define RIVU_VEC_STRIDE   13'h0002
`define RIVU_SP_W         11
`define RIVU_SP_STEP      11'h002

`endif

// ==== rivu_prio_enc.v ====
/*
  Fixed priority encoder: lowest index wins.
  Assumes request bits already qualified by enables.
*/
`timescale 1ns/1ps
`default_nettype none

module rivu_prio_enc #(
  parameter N = 17,
  parameter W = 5
) (
  input  wire [N-1:0] req,
  output reg          any,
  output reg  [W-1:0] idx,
  output reg  [N-1:0] onehot
);

  integer i;

  // Scan from high to low so the lowest index is assigned last and wins
  always @*
  begin
    any    = 1'b0;
    idx    = {W{1'b0}};
    onehot = {N{1'b0}};
    for (i = N - 1; i >= 0; i = i - 1)
    begin
      if (req[i])
      begin
        any    = 1'b1;
        idx    = i[W-1:0];
        onehot = {N{1'b0}};
        onehot[i] = 1'b1;
      end
    end
  end

endmodule // rivu_prio_enc

`default_nettype wire

// ==== rivu_vector_unit.v ====
/*
  Reset and interrupt vector unit of an 8-bit core. Picks the winning
  request, produces its vector, acknowledges the source, handles the
  global enable, stack pointer steps and boot reset relocation.
  Assumes the core pulses insn_boundary and return_from_irq, and that
  nrst already combines every reset source.
*/
// Overview of operation
// - Seventeen interrupt sources plus reset, each with its own vector.
// - A request is taken only if its enable and global enable are set.
// - Vectors sit at the lowest program addresses; reset at zero.
// - Lower vector address wins; priority is fixed.
// - Reset beats everything; external request zero is next.
// - External request zero at 0x002, external request one at 0x004.
// - Timer two compare, overflow, timer one capture, compare A at 0x006-0x00C.
// - Timer one compare B 0x00E, overflow 0x010, timer zero overflow 0x012.
// - Serial transfer done 0x014, receive done 0x016.
// - Transmit buffer empty 0x018, transmit done 0x01A.
// - Converter 0x01C, data memory ready 0x01E, comparator 0x020, two-wire 0x022.
// - All reset causes share the one reset vector.
// - Boot reset fuse moves the reset start address to the boot loader.
// - With that fuse, reset vector is 0x1F00; interrupt vectors stay low.
// - Acceptance clears global enable; return from interrupt sets it.
// - Entry pushes return address, stack pointer minus two; return adds two.
// - Status register is never saved or restored by hardware.
`timescale 1ns/1ps
`default_nettype none
`include "rivu_defs.vh"

module rivu_vector_unit #(
  parameter NUM_SRC = `RIVU_NUM_SRC,
  parameter PC_W    = `RIVU_PC_W,
  parameter SP_W    = `RIVU_SP_W
) (
  // Clock, combined reset and the boot fuse
  input  wire                clk,
  input  wire                nrst,
  input  wire                boot_reset_select_fuse,
  // Pending request levels and their enables, listed in vector order
  input  wire                ext_request_zero,
  input  wire                ext_request_one,
  input  wire                t2_compare_match,
  input  wire                t2_overflow,
  input  wire                t1_capture_event,
  input  wire                t1_compare_match_a,
  input  wire                t1_compare_match_b,
  input  wire                t1_overflow,
  input  wire                t0_overflow,
  input  wire                serial_transfer_done,
  input  wire                receive_done,
  input  wire                tx_buffer_empty,
  input  wire                transmit_done,
  input  wire                adc_conversion_done,
  input  wire                nv_data_mem_ready,
  input  wire                analog_compare_event,
  input  wire                two_wire_event,
  input  wire [NUM_SRC-1:0]  irq_enable,
  // Core handshake and software writes to the enable bit and stack pointer
  input  wire                insn_boundary,
  input  wire                return_from_irq,
  input  wire                global_enable_set,
  input  wire                global_enable_clear,
  input  wire [PC_W-1:0]     return_pc,
  input  wire                sp_load,
  input  wire [SP_W-1:0]     sp_load_value,
  // Every output below is a flip-flop
  output reg                 global_irq_enable,
  output reg                 vector_valid,
  output reg  [PC_W-1:0]     vector_addr,
  output reg  [NUM_SRC-1:0]  irq_ack,
  output reg                 reset_fetch,
  output reg  [PC_W-1:0]     reset_start_addr,
  output reg                 push_valid,
  output reg  [PC_W-1:0]     push_pc,
  output reg  [SP_W-1:0]     stack_ptr
);

  localparam VEC_W = `RIVU_VEC_W;

  // Startup sequencer states
  // Two states suffice: one reset cycle, then normal running
  localparam ST_RESET = 1'b0;
  localparam ST_RUN   = 1'b1;

  wire [NUM_SRC-1:0] raw_req;
  wire [NUM_SRC-1:0] qual_req;
  wire               win_any;
  wire [VEC_W-1:0]   win_idx;
  wire [NUM_SRC-1:0] win_onehot;
  wire               take_irq;
  wire [PC_W-1:0]    win_vec;

  reg                state;
  reg                next_state;

  // Bit order equals vector order, so bit 0 maps to 0x002 and bit 16 to 0x022
  assign raw_req = {two_wire_event, analog_compare_event, nv_data_mem_ready,
                    adc_conversion_done, transmit_done, tx_buffer_empty,
                    receive_done, serial_transfer_done,
                    t0_overflow, t1_overflow, t1_compare_match_b,
                    t1_compare_match_a, t1_capture_event, t2_overflow,
                    t2_compare_match, ext_request_one, ext_request_zero};

  // Gate each request by its own enable and by the global enable
  // A masked request is not stored here; its source flag keeps it pending
  // until software enables it, so nothing is lost while the bit is low
  assign qual_req = raw_req & irq_enable & {NUM_SRC{global_irq_enable}};

  // Re-evaluated combinationally every cycle
  // A flat scan costs logic depth but keeps the fixed order easy to audit
  rivu_prio_enc #(
    .N (NUM_SRC),
    .W (VEC_W)
  ) u_prio (
    .req    (qual_req),
    .any    (win_any),
    .idx    (win_idx),
    .onehot (win_onehot)
  );

  // Vector number is index plus one, so address is 2*(index+1)
  // Index 16 lands on 0x022, so the upper address bits always stay zero
  assign win_vec = `RIVU_VEC_STRIDE *
                   ({{(PC_W-VEC_W){1'b0}}, win_idx} + {{(PC_W-1){1'b0}}, 1'b1});

  // Only sample at a boundary and never while the sequencer is still in ST_RESET
  // Blocking the first cycle after release keeps a vector from ever
  // coinciding with the reset fetch pulse
  assign take_irq = win_any & insn_boundary & (state == ST_RUN);

  // Reset sequencer: the cycle after the ST_RESET cycle presents the reset vector
  always @*
  begin
    case (state)
      ST_RESET: next_state = ST_RUN;
      ST_RUN:   next_state = ST_RUN;
      default:  next_state = ST_RESET;
    endcase
  end

  // Every reset cause arrives via nrst, so one reset vector serves all
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state            <= ST_RESET;
      reset_fetch      <= 1'b0;
      reset_start_addr <= `RIVU_RESET_VEC;
    end
    else
    begin
      state       <= next_state;
      reset_fetch <= (state == ST_RESET);
      // Fuse read after release, never under the asynchronous reset
      // Limitation: a fuse change is only seen at the next reset
      if (state == ST_RESET)
      begin
        if (boot_reset_select_fuse)
          reset_start_addr <= `RIVU_BOOT_VEC;
        else
          reset_start_addr <= `RIVU_RESET_VEC;
      end
    end
  end

  // Global enable: accept clears it, return sets it; accept wins a tie
  // A software set and clear in one cycle leave the bit set
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      global_irq_enable <= 1'b0;
    else if (take_irq)
      global_irq_enable <= 1'b0;
    else if (return_from_irq || global_enable_set)
      global_irq_enable <= 1'b1;
    else if (global_enable_clear)
      global_irq_enable <= 1'b0;
  end

  // Vector and single acknowledge, one-cycle pulses per accept
  // vector_addr and push_pc hold until the next accept, so the core may read late
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vector_valid <= 1'b0;
      vector_addr  <= `RIVU_RESET_VEC;
      irq_ack      <= {NUM_SRC{1'b0}};
      push_valid   <= 1'b0;
      push_pc      <= {PC_W{1'b0}};
    end
    else
    begin
      vector_valid <= take_irq;
      push_valid   <= take_irq;
      irq_ack      <= take_irq ? win_onehot : {NUM_SRC{1'b0}};
      if (take_irq)
      begin
        vector_addr <= win_vec;                    // interrupt vectors stay low
        push_pc     <= return_pc;                  // no status copy
      end
    end
  end

  // Stack pointer: two bytes per return address, load from software wins
  // No bound check: the pointer wraps, so software must place it first
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      stack_ptr <= {SP_W{1'b0}};
    else if (sp_load)
      stack_ptr <= sp_load_value;
    else if (take_irq)
      stack_ptr <= stack_ptr - `RIVU_SP_STEP;
    else if (return_from_irq)
      stack_ptr <= stack_ptr + `RIVU_SP_STEP;
  end

endmodule // rivu_vector_unit

`default_nettype wire

// ==== rivu_vu_properties.sv ====
/* Port checker for the vector unit.
   Assumes one clock and nrst async low. */
`timescale 1ns/1ps
`default_nettype none
module rivu_vu_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [16:0] irq_enable,
  input wire logic        insn_boundary,
  input wire logic        return_from_irq,
  input wire logic        sp_load,
  input wire logic        global_irq_enable,
  input wire logic        vector_valid,
  input wire logic [12:0] vector_addr,
  input wire logic [16:0] irq_ack,
  input wire logic        push_valid,
  input wire logic [10:0] stack_ptr
);
  // One domain, so clock and reset are stated once
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  ack_onehot_a: assert property (vector_valid |-> $onehot(irq_ack))
    else $error("ack not one-hot");
  ack_alone_a: assert property (|irq_ack |-> vector_valid)
    else $error("ack without accept");
  ack_matches_a: assert property (vector_valid |->
    irq_ack == 17'h00001 << (vector_addr[5:1] - 5'h01))
    else $error("ack and vector disagree");
  push_pair_a: assert property (push_valid == vector_valid)
    else $error("push not paired");
  ie_clear_a: assert property (vector_valid |-> !global_irq_enable)
    else $error("global enable kept");
  ie_return_a: assert property ((return_from_irq && !global_irq_enable) |=>
    global_irq_enable)
    else $error("return left enable low");
  take_cause_a: assert property (vector_valid |->
    $past(insn_boundary & global_irq_enable))
    else $error("accept without boundary");
  ack_enabled_a: assert property (vector_valid |->
    (irq_ack & ~$past(irq_enable)) == 17'h00000)
    else $error("disabled source acked");
  vec_low_a: assert property (vector_valid |-> vector_addr inside {[13'h02:13'h22]})
    else $error("vector out of range");
  sp_down_a: assert property (vector_valid |->
    stack_ptr == $past(stack_ptr) - 11'h002)
    else $error("stack not stepped");
  sp_up_a: assert property ((return_from_irq && !global_irq_enable && !sp_load) |=>
    stack_ptr == $past(stack_ptr) + 11'h002)
    else $error("stack not raised");
endmodule // rivu_vu_chk
bind rivu_vector_unit rivu_vu_chk u_chk (
  .clk               (clk),
  .nrst              (nrst),
  .irq_enable        (irq_enable),
  .insn_boundary     (insn_boundary),
  .return_from_irq   (return_from_irq),
  .sp_load           (sp_load),
  .global_irq_enable (global_irq_enable),
  .vector_valid      (vector_valid),
  .vector_addr       (vector_addr),
  .irq_ack           (irq_ack),
  .push_valid        (push_valid),
  .stack_ptr         (stack_ptr)
);
`default_nettype wire

// ==== rivu_core_model.sv ====
/* Core fetch model: boundaries and handler return.
   Assumes the unit's vector_valid pulse. */
`timescale 1ns/1ps
`default_nettype none
module rivu_core_model (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic       vector_valid,
  input wire logic [3:0] ret_delay,
  output var logic       insn_boundary,
  output var logic       return_from_irq
);
  logic [3:0] cnt;
  logic       busy;
  // Handler runs ret_delay plus one cycles; no boundary is offered meanwhile
  always @(negedge clk or negedge nrst)
    if (!nrst)
    begin
      insn_boundary <= 1'b0;
      return_from_irq <= 1'b0;
      busy <= 1'b0;
      cnt <= 4'h0;
    end
    else
    begin
      insn_boundary <= !busy && !vector_valid;
      // Return pulses for one cycle once the handler count has run out
      return_from_irq <= busy && !vector_valid && cnt == 4'h0;
      if (vector_valid)
      begin
        busy <= 1'b1;
        cnt <= ret_delay;
      end
      else if (busy && cnt == 4'h0)
        busy <= 1'b0;
      else if (busy)
        cnt <= cnt - 4'h1;
    end
endmodule // rivu_core_model
`default_nettype wire

// ==== rivu_vector_unit_tb.sv ====
/* Testbench for the vector unit.
   Assumes the core model and checker. */
`timescale 1ns/1ps
`default_nettype none
module rivu_vector_unit_tb;
  typedef struct packed {logic [16:0] r, e, a; logic [12:0] v;} rivu_row_t;
  rivu_row_t rows [0:20];
  logic clk = 0, nrst = 0, fuse = 0, gset = 0, gclr = 0, spl = 0;
  logic [16:0] req = 0, en = 0;
  logic [12:0] rpc = 0;
  logic [3:0] dly = 0;
  wire logic ib, ret, ie, vv, rf, pv;
  wire logic [12:0] va, rsa, ppc;
  wire logic [16:0] ack;
  wire logic [10:0] sp;
  int err_total = 0, samples_checked = 0;
  bit hit;
  rivu_vector_unit DUT (.clk(clk), .nrst(nrst), .boot_reset_select_fuse(fuse),
    .ext_request_zero(req[0]), .ext_request_one(req[1]), .t2_compare_match(req[2]),
    .t2_overflow(req[3]), .t1_capture_event(req[4]), .t1_compare_match_a(req[5]),
    .t1_compare_match_b(req[6]), .t1_overflow(req[7]), .t0_overflow(req[8]),
    .serial_transfer_done(req[9]), .receive_done(req[10]), .tx_buffer_empty(req[11]),
    .transmit_done(req[12]), .adc_conversion_done(req[13]), .nv_data_mem_ready(req[14]),
    .analog_compare_event(req[15]), .two_wire_event(req[16]), .irq_enable(en),
    .insn_boundary(ib), .return_from_irq(ret), .global_enable_set(gset),
    .global_enable_clear(gclr), .return_pc(rpc), .sp_load(spl), .sp_load_value(11'h45F),
    .global_irq_enable(ie), .vector_valid(vv), .vector_addr(va), .irq_ack(ack),
    .reset_fetch(rf), .reset_start_addr(rsa), .push_valid(pv), .push_pc(ppc), .stack_ptr(sp));
  rivu_core_model u_core (.clk(clk), .nrst(nrst), .vector_valid(vv), .ret_delay(dly),
    .insn_boundary(ib), .return_from_irq(ret));
  initial forever #12.5 clk = ~clk;
  task chk(input string n, input logic [16:0] x, input logic [16:0] g);
    samples_checked++;
    if (g !== x)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, x, g);
    end
  endtask
  task summarize;
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Reset, then look for the one-cycle start fetch and load the stack
  task do_reset(input logic f);
    @(negedge clk); nrst = 0; fuse = f; req = 0;
    repeat (6) @(negedge clk);
    chk("ie_rst", 0, ie);
    chk("fetch_rst", 0, rf);
    nrst = 1;
    @(negedge clk); chk("fetch", 1, rf);
    chk("start", f ? 13'h1F00 : 13'h0000, rsa);
    @(negedge clk); chk("fetch_end", 0, rf);
    spl = 1; @(negedge clk); spl = 0;
    $display("reset test done");
  endtask
  // Bounded wait; the current cycle counts as the first
  task wait_vv(input int n);
    hit = 0;
    for (int k = 0; k < n && !hit; k++)
    begin
      hit = vv;
      if (!hit) @(negedge clk);
    end
  endtask
  task run_row(input rivu_row_t w, input int i);
    req = w.r; en = w.e; rpc = 13'h1000 + 13'(i); dly = i[0] ? 4'h9 : 4'h0; gset = 1;
    @(negedge clk); gset = 0;
    wait_vv(12);
    chk("accept", w.a != 0, hit);
    if (w.a != 0 && !hit) summarize;
    if (hit)
    begin
      chk("vector", w.v, va);
      chk("vector_tab", w.v, va);
      chk("ack", w.a, ack);
      chk("push_valid", 1, pv);
      chk("push_pc", rpc, ppc);
      chk("sp_dec", 11'h45D, sp);
      chk("ie_clr", 0, ie);
      req = 0;
      for (int k = 0; k < 20 && ie !== 1'b1; k++) @(negedge clk);
      chk("ie_set", 1, ie);
      chk("sp_inc", 11'h45F, sp);
      chk("ack_pulse", 0, ack);
      chk("push_only_pc", rpc, ppc);
      if (ie !== 1'b1) summarize;
    end
    $display("row %0d done", i);
  endtask
  initial
  begin
    for (int i = 0; i < 17; i++) rows[i] = '{17'(1 << i), 17'h1FFFF, 17'(1 << i), 13'(2 * i + 2)};
    rows[17] = '{17'h1FFFF, 17'h1FFFF, 17'h00001, 13'h0002};
    rows[18] = '{17'h1FFFF, 17'h1FFFE, 17'h00002, 13'h0004};
    rows[19] = '{17'h14000, 17'h1FFFF, 17'h04000, 13'h001E};
    rows[20] = '{17'h00020, 17'h1FFDF, 17'h00000, 13'h0000};
    do_reset(0);
    foreach (rows[i]) run_row(rows[i], i);
    // Clear the global enable first so the request cannot slip in
    gclr = 1; @(negedge clk); gclr = 0; req = 17'h00001; en = 17'h1FFFF;
    wait_vv(10); chk("refused", 0, hit);
    $display("global off test done");
    run_row(rows[0], 0);
    do_reset(1);
    run_row(rows[1], 1);
    summarize;
  end
endmodule // rivu_vector_unit_tb
`default_nettype wire
